// *** include/apc_pkg.sv ***
`default_nettype none
package apc_pkg;

   // Register offsets on the serial control bus
   localparam logic [7:0] APC_OFS_MAIN1  = 8'h01;
   localparam logic [7:0] APC_OFS_ANALOG = 8'h40;
   localparam logic [7:0] APC_OFS_MAIN2  = 8'h43;

   // Reset values
   localparam logic [7:0] APC_RST_MAIN1  = 8'h08;
   localparam logic [7:0] APC_RST_ANALOG = 8'h00;
   localparam logic [7:0] APC_RST_MAIN2  = 8'h00;

   // Seven-bit bus address of the device
   localparam logic [6:0] APC_DEV_ADDR = 7'h34;

   // Field positions, first control register
   localparam int APC_M1_FAST   = 7;
   localparam int APC_M1_RATE   = 6;
   localparam int APC_M1_FMT_HI = 5;
   localparam int APC_M1_FMT_LO = 4;
   localparam int APC_M1_WL_HI  = 1;
   localparam int APC_M1_WL_LO  = 0;
   // Field positions, second control register
   localparam int APC_M2_TONE   = 7;
   localparam int APC_M2_EQBYP  = 1;
   // Field positions, analog control register
   localparam int APC_AN_MONO   = 7;
   localparam int APC_AN_SIDE   = 6;
   localparam int APC_AN_DM_HI  = 3;
   localparam int APC_AN_DM_LO  = 2;
   localparam int APC_AN_INPUT  = 1;
   localparam int APC_AN_PDN    = 0;

   // Bit counts of one serial byte
   localparam logic [3:0] APC_BYTE_BITS = 4'h8;
   localparam logic [3:0] APC_LAST_TX   = 4'h7;

   // Word lengths in bits
   localparam logic [4:0] APC_WBITS_16 = 5'h10;
   localparam logic [4:0] APC_WBITS_18 = 5'h12;
   localparam logic [4:0] APC_WBITS_20 = 5'h14;
   localparam logic [4:0] APC_WBITS_24 = 5'h18;

   typedef enum logic [1:0] {
      APC_FMT_LEFT  = 2'h0,
      APC_FMT_RIGHT = 2'h1,
      APC_FMT_I2S   = 2'h2,
      APC_FMT_RSVD  = 2'h3
   } apc_fmt_e;

   typedef enum logic [1:0] {
      APC_DM_OFF  = 2'h0,
      APC_DM_48K  = 2'h1,
      APC_DM_44K1 = 2'h2,
      APC_DM_RSVD = 2'h3
   } apc_deemph_e;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} apc_state_e;
   typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} apc_phase_e;

   typedef struct packed {
      logic        fast_load_sel;
      logic        bit_clock_rate_sel;
      apc_fmt_e    audio_fmt;
      logic [1:0]  word_len_sel;
      logic [4:0]  word_bits;
      logic        tone_load_sel;
      logic        eq_bypass;
      logic        adc_mono_en;
      logic        mono_side_sel;
      apc_deemph_e deemph_sel;
      logic        input_pair_sel;
      logic        analog_powerdown;
   } apc_cfg_s;

   localparam apc_cfg_s APC_CFG_RST = '{
      fast_load_sel:      1'b0,
      bit_clock_rate_sel: 1'b0,
      audio_fmt:          APC_FMT_LEFT,
      word_len_sel:       2'h0,
      word_bits:          APC_WBITS_16,
      tone_load_sel:      1'b0,
      eq_bypass:          1'b0,
      adc_mono_en:        1'b0,
      mono_side_sel:      1'b0,
      deemph_sel:         APC_DM_OFF,
      input_pair_sel:     1'b0,
      analog_powerdown:   1'b0
   };

   function automatic logic [4:0] apc_word_bits(input logic [1:0] sel);
      logic [4:0] bits;
      unique case (sel)
         2'h0: bits = APC_WBITS_16;
         2'h1: bits = APC_WBITS_18;
         2'h2: bits = APC_WBITS_20;
         2'h3: bits = APC_WBITS_24;
      endcase
      return bits;
   endfunction : apc_word_bits

endpackage : apc_pkg
`default_nettype wire

// *** hdl/apc_ctrl_regs.sv ***
// Behaviour
// [R1] First register bit 7: 0 normal operation, 1 fast-load mode.
// [R2] First register bit 6: bit clock 32 times sample rate, or 64 when set.
// [R3] First register bits 5-4 pick left, right or I2S format; 11 is reserved.
// [R4] First register bits 1-0 pick word length 16, 18, 20 or 24 bits.
// [R5] Second register bit 7: normal tone control, or downloaded bass and treble.
// [R6] Second register bit 1 set forces all equalizer filters to all-pass.
// [R7] Analog register bit 7 set makes the ADC output monaural from B inputs.
// [R8] Analog register bit 6 picks left (0) or right (1) B input for mono.
// [R9] Analog register bits 3-2: de-emphasis off, 48 kHz, 44.1 kHz; 11 reserved.
// [R10] Analog register bit 1 routes A inputs when 0, B inputs when 1.
// [R11] Analog register bit 0 set powers down the analog section.
// [R12] Host writes reserved bits as laid out: bit 3 one, the others zero.
`timescale 1ns/1ns
`default_nettype none
module apc_ctrl_regs #(
   parameter logic [6:0] DEV_ADDR = apc_pkg::APC_DEV_ADDR
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output var  logic             sda_o,
   output var  logic             sda_oe_n,
   output var  apc_pkg::apc_cfg_s cfg
);
   import apc_pkg::*;

   // Reserved bus addresses cannot be served
   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_addr_chk
      $error("DEV_ADDR lies in a reserved address range");
   end

   logic [2:0]  scl_sy_reg;
   logic [2:0]  sda_sy_reg;
   logic        scl_q_reg;
   logic        sda_q_reg;
   logic        scl_d_reg;
   logic        sda_d_reg;
   apc_state_e  state_reg;
   apc_phase_e  phase_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  rx_sh_reg;
   logic [7:0]  tx_sh_reg;
   logic [7:0]  sub_reg;
   logic        rd_mode_reg;
   logic        master_ack_reg;
   logic [7:0]  main1_reg;
   logic [7:0]  main2_reg;
   logic [7:0]  analog_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        byte_end;
   logic        sub_mapped;
   logic        ack_now;
   logic        wr_en;
   logic [7:0]  rd_byte;

   // Pins pass three flops; a level counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sy_reg <= 3'h7;
         sda_sy_reg <= 3'h7;
         scl_q_reg  <= 1'b1;
         sda_q_reg  <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_d_reg  <= 1'b1;
      end else if (ce) begin
         scl_sy_reg <= {scl_sy_reg[1:0], scl_i};
         sda_sy_reg <= {sda_sy_reg[1:0], sda_i};
         if (scl_sy_reg[1] == scl_sy_reg[2]) begin
            scl_q_reg <= scl_sy_reg[2];
         end
         if (sda_sy_reg[1] == sda_sy_reg[2]) begin
            sda_q_reg <= sda_sy_reg[2];
         end
         scl_d_reg <= scl_q_reg;
         sda_d_reg <= sda_q_reg;
      end
   end

   assign scl_rise  = scl_q_reg & ~scl_d_reg;
   assign scl_fall  = ~scl_q_reg & scl_d_reg;
   // Data edges only count while the clock line stays high
   assign bus_start = scl_q_reg & scl_d_reg & sda_d_reg & ~sda_q_reg;
   assign bus_stop  = scl_q_reg & scl_d_reg & ~sda_d_reg & sda_q_reg;
   assign byte_end  = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == APC_BYTE_BITS);

   always_comb begin
      sub_mapped = 1'b1;
      rd_byte    = 8'h00;
      unique case (sub_reg)
         APC_OFS_MAIN1:  rd_byte = main1_reg;
         APC_OFS_MAIN2:  rd_byte = main2_reg;
         APC_OFS_ANALOG: rd_byte = analog_reg;
         default:        sub_mapped = 1'b0;
      endcase
   end

   always_comb begin
      unique case (phase_reg)
         PH_ADDR: ack_now = (rx_sh_reg[7:1] == DEV_ADDR);
         PH_SUB:  ack_now = 1'b1;
         PH_DATA: ack_now = sub_mapped;
         default: ack_now = 1'b0;
      endcase
   end

   assign wr_en = byte_end && (phase_reg == PH_DATA) && sub_mapped;

   // Serial bus slave; open drain, so only a low level is ever driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         phase_reg      <= PH_ADDR;
         bit_cnt_reg    <= 4'h0;
         rx_sh_reg      <= 8'h00;
         tx_sh_reg      <= 8'h00;
         sub_reg        <= 8'h00;
         rd_mode_reg    <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_oe_n       <= 1'b1;
      end else if (ce) begin
         if (bus_start) begin
            state_reg   <= ST_RX;
            phase_reg   <= PH_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_n    <= 1'b1;
         end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_n  <= 1'b1;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
               end
               ST_RX: begin
                  if (scl_rise && bit_cnt_reg != APC_BYTE_BITS) begin
                     rx_sh_reg   <= {rx_sh_reg[6:0], sda_q_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (byte_end) begin
                     bit_cnt_reg <= 4'h0;
                     // Unknown address or data byte for an unmapped register is refused
                     state_reg   <= ack_now ? ST_ACK : ST_IDLE;
                     sda_oe_n    <= ~ack_now;
                     if (phase_reg == PH_ADDR) begin
                        rd_mode_reg <= rx_sh_reg[0];
                     end
                     if (phase_reg == PH_SUB) begin
                        sub_reg <= rx_sh_reg;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rd_mode_reg && phase_reg == PH_ADDR) begin
                        tx_sh_reg <= {rd_byte[6:0], 1'b0};
                        sda_oe_n  <= rd_byte[7];
                        state_reg <= ST_TX;
                     end else begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= ST_RX;
                        phase_reg <= (phase_reg == PH_ADDR) ? PH_SUB : PH_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == APC_LAST_TX) begin
                        sda_oe_n    <= 1'b1;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= ST_RACK;
                     end else begin
                        sda_oe_n    <= tx_sh_reg[7];
                        tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     master_ack_reg <= ~sda_q_reg;
                  end else if (scl_fall) begin
                     // No address increment: a burst repeats the same register
                     if (master_ack_reg) begin
                        tx_sh_reg <= {rd_byte[6:0], 1'b0};
                        sda_oe_n  <= rd_byte[7];
                        state_reg <= ST_TX;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_o <= 1'b0;
      end else if (ce) begin
         sda_o <= 1'b0;
      end
   end

   // Register file; reserved bits are stored as written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main1_reg  <= APC_RST_MAIN1;
         main2_reg  <= APC_RST_MAIN2;
         analog_reg <= APC_RST_ANALOG;
      end else if (ce && wr_en) begin
         unique case (sub_reg)
            APC_OFS_MAIN1:  main1_reg  <= rx_sh_reg;
            APC_OFS_MAIN2:  main2_reg  <= rx_sh_reg;
            APC_OFS_ANALOG: analog_reg <= rx_sh_reg;
            default: begin
            end
         endcase
      end
   end

   // Decoded controls for the datapath, one cycle behind the registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= APC_CFG_RST;
      end else if (ce) begin
         cfg.fast_load_sel      <= main1_reg[APC_M1_FAST]; // R1
         cfg.bit_clock_rate_sel <= main1_reg[APC_M1_RATE]; // R2
         // Reserved format keeps the last legal one rather than a bogus frame
         if (main1_reg[APC_M1_FMT_HI:APC_M1_FMT_LO] != APC_FMT_RSVD) begin
            cfg.audio_fmt <= apc_fmt_e'(main1_reg[APC_M1_FMT_HI:APC_M1_FMT_LO]); // R3
         end
         cfg.word_len_sel       <= main1_reg[APC_M1_WL_HI:APC_M1_WL_LO]; // R4
         cfg.word_bits          <= apc_word_bits(main1_reg[APC_M1_WL_HI:APC_M1_WL_LO]); // R4
         cfg.tone_load_sel      <= main2_reg[APC_M2_TONE]; // R5
         cfg.eq_bypass          <= main2_reg[APC_M2_EQBYP]; // R6
         cfg.adc_mono_en        <= analog_reg[APC_AN_MONO]; // R7
         cfg.mono_side_sel      <= analog_reg[APC_AN_SIDE]; // R8
         // Reserved de-emphasis code falls back to off
         if (analog_reg[APC_AN_DM_HI:APC_AN_DM_LO] == APC_DM_RSVD) begin
            cfg.deemph_sel <= APC_DM_OFF; // R9
         end else begin
            cfg.deemph_sel <= apc_deemph_e'(analog_reg[APC_AN_DM_HI:APC_AN_DM_LO]); // R9
         end
         cfg.input_pair_sel     <= analog_reg[APC_AN_INPUT]; // R10
         cfg.analog_powerdown   <= analog_reg[APC_AN_PDN]; // R11
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_fast_load;
      logic [7:0] d;
      (ce && wr_en && sub_reg == APC_OFS_MAIN1, d = rx_sh_reg) ##1 ce
         |=> cfg.fast_load_sel == d[APC_M1_FAST];
   endproperty
   a_fast_load: assert property (p_fast_load) else $error("fast-load not from write"); // R1

   property p_clock_rate;
      ce |=> cfg.bit_clock_rate_sel == $past(main1_reg[APC_M1_RATE]);
   endproperty
   a_clock_rate: assert property (p_clock_rate) else $error("clock rate wrong"); // R2

   property p_fmt_rsvd;
      ce && main1_reg[APC_M1_FMT_HI:APC_M1_FMT_LO] == APC_FMT_RSVD |=> $stable(cfg.audio_fmt);
   endproperty
   a_fmt_rsvd: assert property (p_fmt_rsvd) else $error("reserved format applied"); // R3

   property p_word_24;
      ce && main1_reg[APC_M1_WL_HI:APC_M1_WL_LO] == 2'h3 |=> cfg.word_bits == APC_WBITS_24;
   endproperty
   a_word_24: assert property (p_word_24) else $error("24-bit length wrong"); // R4

   property p_tone;
      (ce && main2_reg[APC_M2_TONE]) [*2] |-> cfg.tone_load_sel;
   endproperty
   a_tone: assert property (p_tone) else $error("tone load source wrong"); // R5

   property p_eq_bypass;
      ce ##1 ce |-> cfg.eq_bypass == $past(main2_reg[APC_M2_EQBYP]);
   endproperty
   a_eq_bypass: assert property (p_eq_bypass) else $error("all-pass bypass wrong"); // R6

   property p_mono;
      ce |=> cfg.adc_mono_en == $past(analog_reg[APC_AN_MONO]);
   endproperty
   a_mono: assert property (p_mono) else $error("mono enable wrong"); // R7

   property p_side;
      ce && !analog_reg[APC_AN_SIDE] |=> !cfg.mono_side_sel;
   endproperty
   a_side: assert property (p_side) else $error("mono side wrong"); // R8

   property p_deemph;
      ce && analog_reg[APC_AN_DM_HI:APC_AN_DM_LO] == APC_DM_RSVD |=> cfg.deemph_sel == APC_DM_OFF;
   endproperty
   a_deemph: assert property (p_deemph) else $error("reserved de-emphasis applied"); // R9

   property p_input;
      ce |=> cfg.input_pair_sel == $past(analog_reg[APC_AN_INPUT]);
   endproperty
   a_input: assert property (p_input) else $error("input pair wrong"); // R10

   property p_powerdown;
      ce && analog_reg[APC_AN_PDN] |=> cfg.analog_powerdown;
   endproperty
   a_powerdown: assert property (p_powerdown) else $error("power-down wrong"); // R11

   property p_c_wr_main1;
      wr_en && sub_reg == APC_OFS_MAIN1;
   endproperty
   c_wr_main1: cover property (p_c_wr_main1);

   property p_c_wr_analog;
      wr_en && sub_reg == APC_OFS_ANALOG;
   endproperty
   c_wr_analog: cover property (p_c_wr_analog);

   property p_c_read;
      state_reg == ST_RACK && scl_fall && master_ack_reg;
   endproperty
   c_read: cover property (p_c_read);

endmodule : apc_ctrl_regs
`default_nettype wire

// *** verification/apc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module apc_host_model (
   input  wire logic clk,
   input  wire logic sda_w,
   output var  logic scl,
   output var  logic sda
);
   // Third of a bit time in clk cycles; must stay at 3 or more
   int q = 10;

   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic put_bit(input logic b);
      tick(q);
      sda <= b;
      tick(q);
      scl <= 1'b1;
      tick(q);
      scl <= 1'b0;
   endtask : put_bit

   // Line is released so the device may drive; sampled late in the high phase
   task automatic get_bit(output logic b);
      tick(q);
      sda <= 1'b1;
      tick(q);
      scl <= 1'b1;
      tick(q);
      b = sda_w;
      scl <= 1'b0;
   endtask : get_bit

   // Also serves as repeated start after an acknowledge
   task automatic start();
      tick(q);
      sda <= 1'b1;
      tick(q);
      scl <= 1'b1;
      tick(q);
      sda <= 1'b0;
      tick(q);
      scl <= 1'b0;
   endtask : start

   task automatic stop();
      tick(q);
      sda <= 1'b0;
      tick(q);
      scl <= 1'b1;
      tick(q);
      sda <= 1'b1;
      tick(q);
   endtask : stop

   task automatic send(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(nak);
   endtask : send

   task automatic recv(input logic nak, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(nak);
   endtask : recv

   task automatic wr(input logic [6:0] a, input logic [7:0] s, d, output logic [2:0] nak);
      start();
      send({a, 1'b0}, nak[2]);
      send(s, nak[1]);
      send(d, nak[0]);
      stop();
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] s, output logic [7:0] d);
      logic n;
      start();
      send({a, 1'b0}, n);
      send(s, n);
      start();
      send({a, 1'b1}, n);
      recv(1'b1, d);
      stop();
   endtask : rd
endmodule : apc_host_model
`default_nettype wire

// *** verification/apc_ctrl_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module apc_ctrl_regs_tb;
   import apc_pkg::*;
   logic       clk   = 1'b0;
   logic       rst_n = 1'b0;
   logic       ce    = 1'b1;
   logic       scl;
   logic       sda_h;
   logic       sda_o;
   logic       sda_oe_n;
   wire logic  sda_w;
   apc_cfg_s   cfg;
   int         miscompares = 0;
   int         checks = 0;
   logic [7:0] rb;
   logic [2:0] nk;
   logic [1:0] fmt_x = 2'h0;
   logic [7:0] ofs [3] = '{APC_OFS_MAIN1, APC_OFS_MAIN2, APC_OFS_ANALOG};
   logic [7:0] sh [3]  = '{APC_RST_MAIN1, APC_RST_MAIN2, APC_RST_ANALOG};

   always #2 clk = ~clk;
   // Open drain with pull-up: either party can pull low
   assign sda_w = sda_h & (sda_oe_n ? 1'b1 : sda_o);

   apc_ctrl_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg(cfg));
   apc_host_model i_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_h));

   task automatic stop_test();
      if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   function automatic logic [7:0] legal(input int r, input logic [7:0] d);
      if (r == 0) return {d[7:6], (d[5:4] == 2'h3) ? 2'h2 : d[5:4], 2'h2, d[1:0]};
      if (r == 1) return d & 8'h82;
      return d & 8'hCF;
   endfunction : legal

   task automatic check_cfg();
      `CHK("fast", sh[0][7], cfg.fast_load_sel)
      `CHK("rate", sh[0][6], cfg.bit_clock_rate_sel)
      `CHK("fmt", fmt_x, cfg.audio_fmt)
      `CHK("wlen", sh[0][1:0], cfg.word_len_sel)
      `CHK("wbits", (sh[0][1:0] == 2'h3) ? 5'h18 : 5'h10 + {2'h0, sh[0][1:0], 1'b0}, cfg.word_bits)
      `CHK("tone", sh[1][7], cfg.tone_load_sel)
      `CHK("eqbyp", sh[1][1], cfg.eq_bypass)
      `CHK("mono", sh[2][7], cfg.adc_mono_en)
      `CHK("side", sh[2][6], cfg.mono_side_sel)
      `CHK("deemph", (sh[2][3:2] == 2'h3) ? 2'h0 : sh[2][3:2], cfg.deemph_sel)
      `CHK("input", sh[2][1], cfg.input_pair_sel)
      `CHK("pdn", sh[2][0], cfg.analog_powerdown)
   endtask : check_cfg

   task automatic put(input int r, input logic [7:0] d);
      i_host.wr(APC_DEV_ADDR, ofs[r], d, nk);
      `CHK("ack", 3'h0, nk)
      sh[r] = d;
      // Reserved format code leaves the last legal format in force
      if (r == 0 && d[5:4] != 2'h3) fmt_x = d[5:4];
      i_host.rd(APC_DEV_ADDR, ofs[r], rb);
      `CHK("readback", d, rb)
      check_cfg();
   endtask : put

   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   initial begin
      void'($urandom(32'h1689));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check_cfg();
      for (int r = 0; r < 3; r++) begin
         i_host.rd(APC_DEV_ADDR, ofs[r], rb);
         `CHK("rstval", sh[r], rb)
      end
      // Every code of each field except reserved format, reserved de-emphasis included
      for (int i = 0; i < 4; i++) begin
         put(0, 8'h08 | 8'(i) | (8'(i % 3) << 4) | (8'(i) << 6));
         put(1, (8'(i % 2) << 7) | (8'(i / 2) << 1));
         put(2, (8'(i) << 6) | (8'(i) << 2) | 8'(i));
      end
      // Burst read: a master acknowledge repeats the same register
      i_host.start();
      i_host.send({APC_DEV_ADDR, 1'b0}, nk[2]);
      i_host.send(APC_OFS_ANALOG, nk[1]);
      i_host.start();
      i_host.send({APC_DEV_ADDR, 1'b1}, nk[0]);
      i_host.recv(1'b0, rb);
      `CHK("burst1", sh[2], rb)
      i_host.recv(1'b1, rb);
      i_host.stop();
      `CHK("burst2", sh[2], rb)
      `CHK("burst_ack", 3'h0, nk)
      // Reserved format after I2S: the applied format must stay I2S
      put(0, 8'h6A);
      put(0, 8'hB9);
      // Reset in mid-run brings every register back to its reset value
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      sh = '{APC_RST_MAIN1, APC_RST_MAIN2, APC_RST_ANALOG};
      fmt_x = 2'h0;
      repeat (3) @(posedge clk);
      check_cfg();
      i_host.rd(APC_DEV_ADDR, APC_OFS_MAIN1, rb);
      `CHK("rst_mid", APC_RST_MAIN1, rb)
      // Foreign device address: no acknowledge, nothing stored
      i_host.wr(APC_DEV_ADDR ^ 7'h01, APC_OFS_MAIN1, 8'hC9, nk);
      `CHK("addr_nak", 3'h7, nk)
      check_cfg();
      // Unmapped subaddress: data refused, reads back zero
      i_host.wr(APC_DEV_ADDR, 8'h02, 8'h55, nk);
      `CHK("sub_nak", 3'h1, nk)
      i_host.rd(APC_DEV_ADDR, 8'h02, rb);
      `CHK("sub_rd", 8'h00, rb)
      // Frozen clock enable: the device must ignore the whole frame
      @(posedge clk);
      ce <= 1'b0;
      i_host.wr(APC_DEV_ADDR, APC_OFS_ANALOG, ~sh[2] & 8'hCF, nk);
      `CHK("ce_nak", 3'h7, nk)
      check_cfg();
      ce <= 1'b1;
      // Random traffic, alternating prompt and slow host timing
      for (int k = 0; k < 12; k++) begin
         int r;
         r = $urandom_range(2);
         i_host.q = 10 + (k % 2) * 6;
         put(r, legal(r, 8'($urandom)));
      end
      stop_test();
   end
endmodule : apc_ctrl_regs_tb
`default_nettype wire
